// >>> cmpl_defs.vh
// Register map, field positions, reset values and divider constants for the
// comparator output and latch-source block. Included by cmpl_top.v only.
`ifndef CMPL_DEFS_VH
`define CMPL_DEFS_VH

// Byte addresses on the APB register bus
`define CMPL_ADDR_CTRL0      12'h000
`define CMPL_ADDR_CTRL1      12'h004
`define CMPL_ADDR_OUT        12'h008
`define CMPL_ADDR_LSRC       12'h00c
`define CMPL_ADDR_FLAG       12'h010
`define CMPL_ADDR_DIV        12'h014

// Control register 0 fields
`define CMPL_C0_ENABLE       7
`define CMPL_C0_RESULT       6
`define CMPL_C0_PIN_OE       5
`define CMPL_C0_POL          4
`define CMPL_C0_SPEED        2
`define CMPL_C0_HYST         1
`define CMPL_C0_SYNC         0
`define CMPL_C0_WMASK        8'hb7
`define CMPL_C0_RESET        8'h04

// Control register 1 fields
`define CMPL_C1_RISE         7
`define CMPL_C1_FALL         6
`define CMPL_C1_WMASK        8'hf1
`define CMPL_C1_RESET        8'h00

// Latch source select fields
`define CMPL_LS_PIN_SET      7
`define CMPL_LS_CLK_SET      6
`define CMPL_LS_CMP_SET      4
`define CMPL_LS_PIN_RST      3
`define CMPL_LS_CLK_RST      2
`define CMPL_LS_CMP_RST      0
`define CMPL_LS_WMASK        8'hdd
`define CMPL_LS_RESET        8'h00

// Flag register and divider register
`define CMPL_FLAG_BIT        0
`define CMPL_DIV_RESET       3'h0
`define CMPL_DIV_BASE        4'h2

`endif

// >>> cmpl_top.v
// Digital side of one analog comparator plus the set/reset source selection
// of the latch it feeds, with an APB slave for its registers.
// Assumes the raw comparator decision arrives already resolved to a level,
// and the timer source clock arrives synchronous to clk_sys as a level.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cmpl_defs.vh"

module cmpl_top (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rst_b,

	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,

	// Analog decision, latch pin, timer clock and port state
	input  wire        cmp_raw_decision,
	input  wire        latch_input_pin,
	input  wire        timer_source_clock,
	input  wire        port_data_latch,
	input  wire        port_direction_bit,

	// Pin and timer outputs
	output reg         cmp_pin_value,
	output reg         cmp_pin_oe_b,
	output reg         cmp_timer_gate,

	// Latch observation
	output reg         latch_set_in,
	output reg         latch_reset_in,
	output reg         latch_q,

	// Flag copy and analog trim
	output reg         cmp_int_flag_out,
	output reg         cmp_speed_select,
	output reg         cmp_hyst_en
);

	// Software-visible state
	reg  [7:0] cmp_control_0_q;
	reg  [7:0] cmp_control_1_q;
	reg  [7:0] latch_source_select_q;
	reg  [2:0] div_sel_q;
	reg        cmp_int_flag_q;

	// Result pipeline and timer clock history
	reg        cmp_result_q;
	reg        cmp_result_prev_q;
	reg        cmp_synced_result_q;
	reg        tclk_prev_q;

	// Divider for the latch clock
	reg  [8:0] div_cnt_q;
	reg        latch_divided_clock_q;

	// Read word chosen by the address during setup
	reg [31:0] rd_word_d;

	// Control bit aliases
	wire       cmp_enable_bit;
	wire       cmp_polarity;
	wire       cmp_sync_en;
	wire       cmp_pin_out_en;

	// Result path and edge detection
	wire       cmp_result_now;
	wire       cmp_ext_result;
	wire       tclk_fall;
	wire       rise_hit;
	wire       fall_hit;
	wire       edge_hit;

	// Bus strobes and flag clear
	wire       wr_en;
	wire       setup_phase;
	wire       clr_flag;

	// Latch source combination and divider terminal count
	wire       set_d;
	wire       reset_d;
	wire [8:0] div_last;

	// Reads as one byte in the low lane with upper bits zero
	function [31:0] byte_word;
		input [7:0] b;
		begin
			byte_word = {24'h000000, b};
		end
	endfunction

	// Terminal count of the divider: period 2^(code+2) cycles
	function [8:0] div_term;
		input [2:0] code;
		reg   [9:0] period;
		begin
			period   = 10'h001 << ({1'b0, code} + `CMPL_DIV_BASE);
			div_term = period[8:0] - 9'h001;
		end
	endfunction

	// True for the six mapped byte addresses; shared by data and error
	// decode so that a hole can never return stale data without an error
	function addr_known;
		input [11:0] a;
		begin
			case (a)
				`CMPL_ADDR_CTRL0, `CMPL_ADDR_CTRL1, `CMPL_ADDR_OUT,
				`CMPL_ADDR_LSRC, `CMPL_ADDR_FLAG, `CMPL_ADDR_DIV: begin
					addr_known = 1'b1;
				end
				default: begin
					addr_known = 1'b0;
				end
			endcase
		end
	endfunction

	assign cmp_enable_bit = cmp_control_0_q[`CMPL_C0_ENABLE];
	assign cmp_polarity   = cmp_control_0_q[`CMPL_C0_POL];
	assign cmp_sync_en    = cmp_control_0_q[`CMPL_C0_SYNC];
	assign cmp_pin_out_en = cmp_control_0_q[`CMPL_C0_PIN_OE];

	// Raw decision is high when plus input exceeds minus; gated then polarised
	assign cmp_result_now = (cmp_enable_bit & cmp_raw_decision) ^ cmp_polarity;

	// External copy is the live result unless sync is on; then the held value
	assign cmp_ext_result = cmp_sync_en ? cmp_synced_result_q : cmp_result_now;

	// Timer clock falls here; timer counts on the rising edge so they never meet
	assign tclk_fall = tclk_prev_q & ~timer_source_clock;

	// APB strobes: zero-wait access phase
	assign wr_en    = psel & penable & pwrite;
	assign setup_phase = psel & ~penable;
	assign clr_flag = wr_en & (paddr == `CMPL_ADDR_FLAG) & ~pwdata[`CMPL_FLAG_BIT];

	// Edge detection against the value seen one cycle earlier
	assign rise_hit = cmp_result_q & ~cmp_result_prev_q;
	assign fall_hit = ~cmp_result_q & cmp_result_prev_q;

	// Only enabled edges reach the flag
	assign edge_hit = (cmp_control_1_q[`CMPL_C1_RISE] & rise_hit) |
	                  (cmp_control_1_q[`CMPL_C1_FALL] & fall_hit);

	assign div_last = div_term(div_sel_q);

	// Latch set and reset sources
	assign set_d   = (latch_source_select_q[`CMPL_LS_PIN_SET] & latch_input_pin) |
	                 (latch_source_select_q[`CMPL_LS_CLK_SET] & latch_divided_clock_q) |
	                 (latch_source_select_q[`CMPL_LS_CMP_SET] & cmp_ext_result);
	assign reset_d = (latch_source_select_q[`CMPL_LS_PIN_RST] & latch_input_pin) |
	                 (latch_source_select_q[`CMPL_LS_CLK_RST] & latch_divided_clock_q) |
	                 (latch_source_select_q[`CMPL_LS_CMP_RST] & cmp_ext_result);

	// Register writes; reserved and read-only bits are masked off
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmp_control_0_q       <= `CMPL_C0_RESET;
			cmp_control_1_q       <= `CMPL_C1_RESET;
			latch_source_select_q <= `CMPL_LS_RESET;
			div_sel_q             <= `CMPL_DIV_RESET;
		end else if (wr_en) begin
			case (paddr)
				`CMPL_ADDR_CTRL0: begin
					cmp_control_0_q <= pwdata[7:0] & `CMPL_C0_WMASK;
				end
				`CMPL_ADDR_CTRL1: begin
					cmp_control_1_q <= pwdata[7:0] & `CMPL_C1_WMASK;
				end
				`CMPL_ADDR_LSRC: begin
					latch_source_select_q <= pwdata[7:0] & `CMPL_LS_WMASK;
				end
				`CMPL_ADDR_DIV: begin
					div_sel_q <= pwdata[2:0];
				end
				default: begin
					div_sel_q <= div_sel_q;
				end
			endcase
		end
	end

	// Interrupt flag: hardware set beats a software clear in the same cycle
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmp_int_flag_q <= 1'b0;
		end else if (edge_hit) begin
			cmp_int_flag_q <= 1'b1;
		end else if (clr_flag) begin
			cmp_int_flag_q <= 1'b0;
		end
	end

	// Result sampled each cycle; sync copy taken on timer clock falling edge
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmp_result_q        <= 1'b0;
			cmp_result_prev_q   <= 1'b0;
			cmp_synced_result_q <= 1'b0;
			tclk_prev_q         <= 1'b0;
		end else begin
			cmp_result_q      <= cmp_result_now;
			cmp_result_prev_q <= cmp_result_q;
			tclk_prev_q       <= timer_source_clock;
			if (tclk_fall) begin
				cmp_synced_result_q <= cmp_result_now;
			end
		end
	end

	// Divided latch clock: free-running counter, one-cycle pulse at wrap
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt_q             <= 9'h000;
			latch_divided_clock_q <= 1'b0;
		end else if (div_cnt_q >= div_last) begin
			div_cnt_q             <= 9'h000;
			latch_divided_clock_q <= 1'b1;
		end else begin
			div_cnt_q             <= div_cnt_q + 9'h001;
			latch_divided_clock_q <= 1'b0;
		end
	end

	// Pin data; every output is registered, so the pin lags the result a cycle
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmp_pin_value <= 1'b0;
		end else if (cmp_pin_out_en) begin
			cmp_pin_value <= cmp_ext_result;
		end else begin
			cmp_pin_value <= port_data_latch;
		end
	end

	// Pin driver needs output enable, output direction and the enable bit
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmp_pin_oe_b <= 1'b1;
		end else begin
			cmp_pin_oe_b <= ~(cmp_pin_out_en & ~port_direction_bit & cmp_enable_bit);
		end
	end

	// Timer gate source; without sync the timer may see a moving edge
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmp_timer_gate <= 1'b0;
		end else begin
			cmp_timer_gate <= cmp_ext_result;
		end
	end

	// Combined set and reset inputs, shown as levels
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			latch_set_in   <= 1'b0;
			latch_reset_in <= 1'b0;
		end else begin
			latch_set_in   <= set_d;
			latch_reset_in <= reset_d;
		end
	end

	// Latch state; reset wins when both inputs are high at once
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			latch_q <= 1'b0;
		end else if (reset_d) begin
			latch_q <= 1'b0;
		end else if (set_d) begin
			latch_q <= 1'b1;
		end
	end

	// Flag copy for the interrupt controller, one cycle behind the flag
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmp_int_flag_out <= 1'b0;
		end else begin
			cmp_int_flag_out <= cmp_int_flag_q;
		end
	end

	// Analog trim bits; speed leaves reset in the normal mode
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmp_speed_select <= 1'b1;
			cmp_hyst_en      <= 1'b0;
		end else begin
			cmp_speed_select <= cmp_control_0_q[`CMPL_C0_SPEED];
			cmp_hyst_en      <= cmp_control_0_q[`CMPL_C0_HYST];
		end
	end

	// Read mux: each register is one byte in the low lane
	always @* begin
		rd_word_d = 32'h00000000;
		case (paddr)
			`CMPL_ADDR_CTRL0: begin
				rd_word_d = byte_word({cmp_control_0_q[7], cmp_result_q, cmp_control_0_q[5:0]});
			end
			`CMPL_ADDR_CTRL1: begin
				rd_word_d = byte_word(cmp_control_1_q);
			end
			`CMPL_ADDR_OUT: begin
				rd_word_d = byte_word({7'h00, cmp_result_q});
			end
			`CMPL_ADDR_LSRC: begin
				rd_word_d = byte_word(latch_source_select_q);
			end
			`CMPL_ADDR_FLAG: begin
				rd_word_d = byte_word({7'h00, cmp_int_flag_q});
			end
			`CMPL_ADDR_DIV: begin
				rd_word_d = byte_word({5'h00, div_sel_q});
			end
			default: begin
				rd_word_d = 32'h00000000;
			end
		endcase
	end

	// APB answer in the first access cycle; holes answer with an error
	// Reads have no side effects, so only the setup phase matters here
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			prdata  <= addr_known(paddr) ? rd_word_d : 32'h00000000;
			pready  <= 1'b1;
			pslverr <= ~addr_known(paddr);
		end else begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule // cmpl_top

`default_nettype wire

// >>> cmpl_top_asserts.sv
// Checker for the comparator and latch-source block, bus and latch ports.
// Attached by bind in the bench; sees only ports of cmpl_top.
`timescale 1ns/1ps
`default_nettype none
module cmpl_top_asserts (
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        port_direction_bit,
	input wire logic        cmp_pin_oe_b,
	input wire logic        latch_set_in,
	input wire logic        latch_reset_in,
	input wire logic        latch_q,
	input wire logic        cmp_int_flag_out,
	input wire logic        cmp_speed_select
);
	logic flag_wr;
	// Flag register write, the only path allowed to clear the flag
	assign flag_wr = psel && penable && pwrite && paddr == 12'h010;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// Zero-wait slave: answer in the first access cycle, never elsewhere
	ready_in_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
	ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	err_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
	reserved_zero_a: assert property (pready && !pwrite && paddr == 12'h00c |-> prdata[5] == 1'h0 && prdata[1] == 1'h0) else $error("reserved bit set");
	speed_reset_a: assert property ($rose(rst_b) |-> cmp_speed_select) else $error("speed select not one");
	reset_dominant_a: assert property (latch_set_in && latch_reset_in |-> ##[0:1] !latch_q) else $error("set won over reset");
	// Input direction for three cycles must leave the pin undriven
	pin_released_a: assert property (port_direction_bit [*3] |-> cmp_pin_oe_b) else $error("pin driven as input");
	flag_sw_clear_a: assert property ($fell(cmp_int_flag_out) |-> $past(flag_wr, 2)) else $error("flag cleared alone");
endmodule // cmpl_top_asserts
`default_nettype wire

// >>> cmpl_far.sv
// Far-side model: the two analog input voltages and the timer source clock.
// The timer clock stands high until tclk_run is raised by the bench.
`timescale 1ns/1ps
`default_nettype none
module cmpl_far (
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic [7:0] v_plus,
	input  wire logic [7:0] v_minus,
	input  wire logic       tclk_run,
	output logic            cmp_raw_decision,
	output logic            timer_source_clock
);
	logic [1:0] div_q;
	// Equal voltages resolve low; the bench relies on this with both voltages at zero
	assign cmp_raw_decision = v_plus > v_minus;
	// Timer clock toggles every fourth system clock while running
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			div_q <= 2'h0;
			timer_source_clock <= 1'h1;
		end else if (tclk_run) begin
			div_q <= div_q + 2'h1;
			if (div_q == 2'h3)
				timer_source_clock <= ~timer_source_clock;
		end
	end
endmodule // cmpl_far
`default_nettype wire

// >>> cmpl_top_test.sv
// Self-checking bench for cmpl_top with the analog and timer model beside it.
// Assumes zero-wait APB answers; every wait is still bounded.
`timescale 1ns/1ps
`default_nettype none
module cmpl_top_test;
	logic        clk_sys = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err, se, re;
	logic        latch_input_pin = 1'h0, port_data_latch = 1'h0, port_direction_bit = 1'h1, tclk_run = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, r, seed = 32'h0a8e;
	logic [7:0]  v_plus = 8'h00, v_minus = 8'h00, c;
	wire  [31:0] prdata;
	wire         pready, pslverr, cmp_raw_decision, timer_source_clock, cmp_pin_value, cmp_pin_oe_b;
	wire         cmp_timer_gate, latch_set_in, latch_reset_in, latch_q, cmp_int_flag_out, cmp_speed_select, cmp_hyst_en;
	int          failures = 0, compares = 0, cnt;
	cmpl_top uut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.cmp_raw_decision, .latch_input_pin, .timer_source_clock, .port_data_latch, .port_direction_bit,
		.cmp_pin_value, .cmp_pin_oe_b, .cmp_timer_gate, .latch_set_in, .latch_reset_in, .latch_q,
		.cmp_int_flag_out, .cmp_speed_select, .cmp_hyst_en);
	cmpl_far far (.clk_sys, .rst_b, .v_plus, .v_minus, .tclk_run, .cmp_raw_decision, .timer_source_clock);
	// 20 MHz system clock
	initial forever #25 clk_sys = ~clk_sys;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected result: enable gates the decision, then polarity inverts it
	function automatic logic res(input logic [7:0] c0);
		return (c0[7] & (v_plus > v_minus)) ^ c0[4];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer plus an idle cycle, so psel is never set twice in a step
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, 24'h0, d};
		@(posedge clk_sys);
		penable <= 1'h1;
		n = 0;
		do begin @(posedge clk_sys); n++; end while (pready !== 1'h1 && n < 16);
		chk(pready, 1'h1);
		r = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'h0, a, 8'h00);
		chk(r, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic summarize;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Watchdog well beyond the longest expected run
	initial begin
		cyc(20000);
		failures++;
		$display("[ERR] %0t timeout", $time);
		summarize;
	end
	initial begin
		cyc(12);
		rst_b <= 1'h1;
		@(posedge clk_sys);
		// Reset values, reserved bits, unmapped hole, speed and hysteresis
		rd(12'h000, 32'h04);
		rd(12'h00c, 32'h00);
		apb(1'h1, 12'h00c, 8'hff);
		rd(12'h00c, 32'hdd);
		rd(12'h018, 32'h0);
		chk(err, 1'h1);
		apb(1'h1, 12'h000, 8'h02);
		cyc(1);
		chk({cmp_speed_select, cmp_hyst_en}, 2'h1);
		// Random voltages against enable and polarity, read twice
		repeat (16) begin
			seed = lfsr(seed);
			{v_minus, v_plus} <= seed[15:0];
			c = seed[23:16] & 8'h90 | 8'h04;
			apb(1'h1, 12'h000, c);
			cyc(3);
			rd(12'h000, {24'h0, c[7], res(c), c[5:0]});
			rd(12'h008, {31'h0, res(c)});
		end
		// Pin and comparator as latch set and reset sources
		apb(1'h1, 12'h000, 8'h84);
		repeat (12) begin
			seed = lfsr(seed);
			c = seed[7:0] & 8'h99;
			{latch_input_pin, v_plus, v_minus} <= {seed[8], 7'h0, seed[9], 8'h00};
			se = c[7] & seed[8] | c[4] & seed[9];
			re = c[3] & seed[8] | c[0] & seed[9];
			apb(1'h1, 12'h00c, c);
			cyc(4);
			chk({latch_set_in, latch_reset_in}, {se, re});
			if (se | re) chk(latch_q, !re);
		end
		// Divided clock: four pulses in four periods, set and reset in turn
		for (int k = 0; k < 8; k++) begin
			apb(1'h1, 12'h014, k[7:0]);
			apb(1'h1, 12'h00c, k[0] ? 8'h04 : 8'h40);
			cnt = 0;
			repeat (4 << (k + 2)) begin
				@(posedge clk_sys);
				cnt += k[0] ? latch_reset_in : latch_set_in;
			end
			chk(cnt, 4);
		end
		// Edge enables, flipping polarity with the comparator off
		for (int k = 0; k < 4; k++) begin
			apb(1'h1, 12'h000, 8'h04);
			apb(1'h1, 12'h004, k[7:0] << 6);
			apb(1'h1, 12'h010, 8'h00);
			apb(1'h1, 12'h000, 8'h14);
			cyc(3);
			rd(12'h010, k[1]);
			chk(cmp_int_flag_out, k[1]);
			apb(1'h1, 12'h010, 8'h00);
			apb(1'h1, 12'h000, 8'h04);
			cyc(3);
			rd(12'h010, k[0]);
		end
		// Pin override against port latch and direction
		repeat (8) begin
			seed = lfsr(seed);
			c = seed[7:0] & 8'ha0 | 8'h04;
			{port_data_latch, port_direction_bit, v_plus} <= {seed[8], seed[9], 7'h0, seed[10]};
			apb(1'h1, 12'h000, c);
			cyc(3);
			chk(cmp_pin_value, c[5] ? c[7] & seed[10] : seed[8]);
			chk(cmp_pin_oe_b, !(c[5] & c[7] & !seed[9]));
		end
		// Synchronised gate holds until the timer clock falls
		apb(1'h1, 12'h000, 8'h81);
		v_plus <= 8'h00;
		cyc(6);
		v_plus <= 8'h01;
		cyc(6);
		chk(cmp_timer_gate, 1'h0);
		tclk_run <= 1'h1;
		cyc(12);
		chk(cmp_timer_gate, 1'h1);
		summarize;
	end
endmodule // cmpl_top_test
bind cmpl_top cmpl_top_asserts chk_i (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
	.pslverr, .port_direction_bit, .cmp_pin_oe_b, .latch_set_in, .latch_reset_in, .latch_q, .cmp_int_flag_out,
	.cmp_speed_select);
`default_nettype wire
